// file: logic/cycle_timing_defs.vh
`ifndef CYCLE_TIMING_DEFS_VH
`define CYCLE_TIMING_DEFS_VH

// machine cycle phases
`define PHASE_W            2
`define PHASE_FIRST        2'h0
`define PHASE_ALE          2'h0
`define PHASE_LAST         2'h3
// clocks per machine cycle and per timer tick
`define CLK_PER_MCYCLE     4
`define TIMER_SLOW_CLKS    12
`define TIMER_FAST_CLKS    4
`define PRESCALE_W         4
`define PRESCALE_ZERO      4'h0
`define PRESCALE_SLOW_LAST 4'hB
`define PRESCALE_FAST_LAST 4'h3
// instruction length limits, in machine cycles
`define MCYC_W             3
`define MCYC_MIN           3'h1
`define MCYC_MAX           3'h5
`define MCYC_EXT_MOVE      3'h2
`define MCYC_DIR_DIR       3'h3
`define MCYC_ONE           3'h1
// instruction classes offered by the sequencer
`define CLASS_W            2
`define CLASS_BYTES        2'h0
`define CLASS_EXT_READ     2'h1
`define CLASS_EXT_WRITE    2'h2
`define CLASS_DIR_DIR      2'h3
// port 3 bit positions
`define P3_RX              0
`define P3_TX              1
`define P3_IRQ_A           2
`define P3_IRQ_B           3
`define P3_TA_IN           4
`define P3_TB_IN           5
`define P3_WR              6
`define P3_RD              7
// strong pull-up pulse length, in clocks
`define PULLUP_CLKS        2'h2
`define PULLUP_W           2
`define PULLUP_ONE         2'h1
// reset values
`define BYTE_ONES          8'hFF
`define BYTE_ZERO          8'h00

`endif

// file: logic/quasi_port_pin.v
`timescale 1ns/1ns
`include "cycle_timing_defs.vh"

// one quasi-bidirectional pin: strong low, brief strong high, weak hold
module quasi_port_pin (
  input  wire clk,
  input  wire rst_n,
  input  wire level,
  output reg  pull_down,
  output reg  strong_up,
  output reg  weak_up
);

  reg [`PULLUP_W-1:0] burst_reg;
  reg                 last_reg;

  // a 0->1 transition gets a short strong drive to charge the pin fast
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_reg <= {`PULLUP_W{1'b0}};
      last_reg  <= 1'b1;
      pull_down <= 1'b0;
      strong_up <= 1'b0;
      weak_up   <= 1'b1;
    end else begin
      last_reg  <= level;
      pull_down <= ~level;                  // see RULE_17
      if (level && !last_reg) begin
        burst_reg <= `PULLUP_CLKS;          // see RULE_18
      end else if (burst_reg != {`PULLUP_W{1'b0}}) begin
        burst_reg <= burst_reg - 1'b1;
      end
      strong_up <= level && ((!last_reg) || (burst_reg > `PULLUP_ONE)); // see RULE_18
      weak_up   <= level;                   // see RULE_16
    end
  end

endmodule // quasi_port_pin

// file: logic/fast_core_cycle_timing.v
`timescale 1ns/1ns
`include "cycle_timing_defs.vh"

// Contract
// RULE_01: each machine cycle lasts four oscillator clocks.
// RULE_02: one address latch pulse in every machine cycle.
// RULE_03: instructions take one to five machine cycles.
// RULE_04: external data move through pointer takes two machine cycles.
// RULE_05: direct-to-direct move takes three machine cycles.
// RULE_06: normally one machine cycle per instruction byte.
// RULE_07: no idle dummy memory cycles between useful fetches.
// RULE_08: after reset timers advance once per twelve clocks.
// RULE_09: each timer may select one advance per four clocks.
// RULE_10: flag and status effects unchanged; only timing differs.
// RULE_11: board ties external fetch select low for external program memory.
// RULE_12: internal data RAM stays reachable when external fetch is forced.
// RULE_13: upper address port drives upper address byte during external access.
// RULE_14: port 3 bit 6 is write strobe, bit 7 read strobe, low.
// RULE_15: port 3 bits 0..5 carry serial, interrupt and timer inputs.
// RULE_16: port 3 latches set to one on reset, weak pull-up holds high.
// RULE_17: a written zero enables strong pull-down until one or reset.
// RULE_18: zero-to-one write gives brief strong pull-up, then weak.
// RULE_19: strobes active only during external data cycles, else port bits.
// RULE_20: machine cycle counter restarts at first phase on reset release.
module fast_core_cycle_timing (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 ext_fetch_select_n,
  input  wire                 instr_start,
  input  wire [`CLASS_W-1:0]  instr_class,
  input  wire [`MCYC_W-1:0]   instr_bytes,
  input  wire                 internal_ram_sel,
  input  wire [7:0]           ext_addr_high,
  input  wire [7:0]           upper_port_latch,
  input  wire [7:0]           alt_port_latch,
  input  wire                 alt_port_write,
  input  wire                 serial0_tx,
  input  wire [1:0]           timer_fast_sel,
  input  wire [7:0]           alt_function_port_in,
  output reg                  ale,
  output reg                  mcycle_end,
  output reg                  instr_busy,
  output reg                  instr_done,
  output reg                  fetch_external,
  output reg                  internal_ram_access,
  output reg  [7:0]           upper_addr_port,
  output reg  [7:0]           alt_function_port,
  output wire [7:0]           alt_port_pull_down,
  output wire [7:0]           alt_port_strong_up,
  output wire [7:0]           alt_port_weak_up,
  output reg                  serial0_rx,
  output reg                  ext_irq_a,
  output reg                  ext_irq_b,
  output reg                  timer_a_count_in,
  output reg                  timer_b_count_in,
  output reg  [1:0]           timer_tick
);

  // idle and busy sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg                   rst_meta_reg;
  reg                   rst_sync_reg;
  wire                  rst_core_n;
  reg [`PHASE_W-1:0]    phase_reg;
  reg                   state_reg;
  reg                   state_next;
  reg [`MCYC_W-1:0]     mcyc_left_reg;
  reg [`MCYC_W-1:0]     mcyc_left_next;
  reg [`CLASS_W-1:0]    class_reg;
  reg [`CLASS_W-1:0]    class_next;
  reg                   pending_reg;
  reg                   pending_next;
  reg [`MCYC_W-1:0]     pend_len_reg;
  reg [`CLASS_W-1:0]    pend_class_reg;
  reg                   ea_meta_reg;
  reg                   ea_sync_reg;
  reg [7:0]             pin_meta_reg;
  reg [7:0]             pin_sync_reg;
  reg [7:0]             latch_reg;
  reg [`PRESCALE_W-1:0] prescale_reg [0:1];
  wire                  phase_wrap;
  wire                  ext_cycle;
  wire                  rd_active;
  wire                  wr_active;
  wire [7:0]            pin_level;

  // length in machine cycles of an instruction class
  function [`MCYC_W-1:0] class_len;
    input [`CLASS_W-1:0] cls;
    input [`MCYC_W-1:0]  nbytes;
    reg   [`MCYC_W-1:0]  len;
    begin
      len = nbytes;
      case (cls)
        `CLASS_EXT_READ:  len = `MCYC_EXT_MOVE;  // see RULE_04
        `CLASS_EXT_WRITE: len = `MCYC_EXT_MOVE;  // see RULE_04
        `CLASS_DIR_DIR:   len = `MCYC_DIR_DIR;   // see RULE_05
        default:          len = nbytes;          // see RULE_06
      endcase
      // clamp keeps every instruction within the documented range
      if (len < `MCYC_MIN) begin
        len = `MCYC_MIN;                         // see RULE_03
      end else if (len > `MCYC_MAX) begin
        len = `MCYC_MAX;                         // see RULE_03
      end
      class_len = len;
    end
  endfunction

  // true for classes that strobe external data memory
  function is_ext_class;
    input [`CLASS_W-1:0] cls;
    begin
      is_ext_class = (cls == `CLASS_EXT_READ) || (cls == `CLASS_EXT_WRITE);
    end
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_core_n = rst_sync_reg;

  // pin inputs pass two flops before any logic sees them
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ea_meta_reg  <= 1'b1;
      ea_sync_reg  <= 1'b1;
      pin_meta_reg <= `BYTE_ONES;
      pin_sync_reg <= `BYTE_ONES;
    end else begin
      ea_meta_reg  <= ext_fetch_select_n;
      ea_sync_reg  <= ea_meta_reg;
      pin_meta_reg <= alt_function_port_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // four-phase machine cycle counter, first phase after reset
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      phase_reg <= `PHASE_FIRST;                // see RULE_20
    end else if (phase_reg == `PHASE_LAST) begin
      phase_reg <= `PHASE_FIRST;                // see RULE_01
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end
  assign phase_wrap = (phase_reg == `PHASE_LAST);

  // sequencer: a waiting request starts at the next boundary when idle, else at the boundary where the current instruction ends
  always @* begin
    state_next     = state_reg;
    mcyc_left_next = mcyc_left_reg;
    class_next     = class_reg;
    pending_next   = pending_reg;
    // a newer request simply replaces one still waiting
    if (instr_start) begin
      pending_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (phase_wrap && pending_reg) begin
          state_next     = ST_RUN;
          mcyc_left_next = class_len(pend_class_reg, pend_len_reg);
          // class travels unchanged; only the timing is decided here
          class_next     = pend_class_reg;  // see RULE_10
          pending_next   = instr_start;
        end
      end
      ST_RUN: begin
        if (phase_wrap) begin
          if (mcyc_left_reg == `MCYC_ONE) begin
            // back-to-back with no dummy cycle in between
            if (pending_reg) begin
              mcyc_left_next = class_len(pend_class_reg, pend_len_reg); // see RULE_07
              class_next     = pend_class_reg;
              pending_next   = instr_start;
            end else begin
              state_next = ST_IDLE;
            end
          end else begin
            mcyc_left_next = mcyc_left_reg - 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers; pending request held until a boundary
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state_reg      <= ST_IDLE;
      mcyc_left_reg  <= `MCYC_MIN;
      class_reg      <= `CLASS_BYTES;
      pending_reg    <= 1'b0;
      pend_len_reg   <= `MCYC_MIN;
      pend_class_reg <= `CLASS_BYTES;
    end else begin
      state_reg     <= state_next;
      mcyc_left_reg <= mcyc_left_next;
      class_reg     <= class_next;
      pending_reg   <= pending_next;
      // sampled only with the start pulse, so idle inputs cannot leak in
      if (instr_start) begin
        pend_len_reg   <= instr_bytes;
        pend_class_reg <= instr_class;
      end
    end
  end

  // the last machine cycle of an external move carries the strobe
  // limitation: the strobe never spans the first cycle of a move
  assign ext_cycle = (state_reg == ST_RUN) && is_ext_class(class_reg) &&
                     (mcyc_left_reg == `MCYC_ONE);
  // read and write strobes never overlap, the class picks one
  assign rd_active = ext_cycle && (class_reg == `CLASS_EXT_READ);
  assign wr_active = ext_cycle && (class_reg == `CLASS_EXT_WRITE);

  // timing outputs, all registered
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ale        <= 1'b0;
      mcycle_end <= 1'b0;
      instr_busy <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      ale        <= (phase_reg == `PHASE_ALE);  // see RULE_02
      mcycle_end <= phase_wrap;                 // see RULE_01
      instr_busy <= (state_next == ST_RUN);
      instr_done <= (state_reg == ST_RUN) && phase_wrap && (mcyc_left_reg == `MCYC_ONE);
    end
  end

  // program source and internal ram; flags are untouched by timing
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      fetch_external      <= 1'b0;
      internal_ram_access <= 1'b0;
    end else begin
      fetch_external      <= ~ea_sync_reg;      // see RULE_11
      internal_ram_access <= internal_ram_sel;  // see RULE_12
    end
  end

  // upper address byte only while an external access runs
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      upper_addr_port <= `BYTE_ONES;
    end else if ((fetch_external && state_reg == ST_RUN) || ext_cycle) begin
      upper_addr_port <= ext_addr_high;         // see RULE_13
    end else begin
      // outside an access the port shows its own latch
      upper_addr_port <= upper_port_latch;
    end
  end

  // port 3 latch: all ones at reset, software writes afterwards
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      latch_reg <= `BYTE_ONES;                  // see RULE_16
    end else if (alt_port_write) begin
      latch_reg <= alt_port_latch;              // see RULE_17
    end
  end

  // strobes override the latch only in external data cycles
  assign pin_level = {latch_reg[`P3_RD] & ~rd_active,  // see RULE_14
                      latch_reg[`P3_WR] & ~wr_active,  // see RULE_19
                      latch_reg[`P3_TB_IN:`P3_TX+1],
                      latch_reg[`P3_TX] & serial0_tx,
                      latch_reg[`P3_RX]};

  // one quasi-bidirectional driver per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      quasi_port_pin u_pin (
        .clk       (clk),
        .rst_n     (rst_core_n),
        .level     (pin_level[gi]),
        .pull_down (alt_port_pull_down[gi]),
        .strong_up (alt_port_strong_up[gi]),
        .weak_up   (alt_port_weak_up[gi])
      );
    end
  endgenerate

  // alternate inputs from the synchronised pins
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      alt_function_port <= `BYTE_ONES;
      serial0_rx        <= 1'b1;
      ext_irq_a         <= 1'b1;
      ext_irq_b         <= 1'b1;
      timer_a_count_in  <= 1'b1;
      timer_b_count_in  <= 1'b1;
    end else begin
      // the driven level is reported back, not the far side's pull
      alt_function_port <= pin_level;
      serial0_rx        <= pin_sync_reg[`P3_RX];     // see RULE_15
      ext_irq_a         <= pin_sync_reg[`P3_IRQ_A];  // see RULE_15
      ext_irq_b         <= pin_sync_reg[`P3_IRQ_B];  // see RULE_15
      timer_a_count_in  <= pin_sync_reg[`P3_TA_IN];  // see RULE_15
      timer_b_count_in  <= pin_sync_reg[`P3_TB_IN];  // see RULE_15
    end
  end

  // timer prescalers: twelve clocks by default, four when selected
  genvar ti;
  generate
    for (ti = 0; ti < 2; ti = ti + 1) begin : g_tmr
      // >= lets a switch to fast mid-count wrap at once, never overrun
      wire [`PRESCALE_W-1:0] last_cnt;
      assign last_cnt = timer_fast_sel[ti] ? `PRESCALE_FAST_LAST : `PRESCALE_SLOW_LAST; // see RULE_09
      always @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
          prescale_reg[ti] <= `PRESCALE_ZERO;
          timer_tick[ti]   <= 1'b0;
        end else if (prescale_reg[ti] >= last_cnt) begin
          prescale_reg[ti] <= `PRESCALE_ZERO;    // see RULE_08
          timer_tick[ti]   <= 1'b1;
        end else begin
          prescale_reg[ti] <= prescale_reg[ti] + 1'b1;
          timer_tick[ti]   <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // fast_core_cycle_timing

// file: test/fast_core_checker.sv
`timescale 1ns/1ns
// watches the timing block from its own ports only
module fast_core_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       ext_fetch_select_n,
  input wire [1:0] timer_fast_sel,
  input wire       ale,
  input wire       mcycle_end,
  input wire       instr_busy,
  input wire       instr_done,
  input wire       fetch_external,
  input wire [7:0] alt_function_port,
  input wire [7:0] alt_port_pull_down,
  input wire [7:0] alt_port_strong_up,
  input wire [1:0] timer_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // three quiet clocks then the next latch pulse
  sequence ale_gap;
    !ale [*3] ##1 ale;
  endsequence
  // eleven quiet clocks then the next slow tick
  sequence slow_gap;
    (!timer_tick[1]) [*8] ##1 (!timer_tick[1]) [*3] ##1 timer_tick[1];
  endsequence
  a_ale_period: assert property (ale |=> ale_gap) else $error("ale period wrong");
  a_mcycle_period: assert property (mcycle_end |=> !mcycle_end [*3] ##1 mcycle_end)
    else $error("machine cycle end period wrong");
  a_ale_start: assert property ($rose(rst_n) |-> ##[1:8] ale) else $error("no ale after reset");
  a_done_in_busy: assert property (instr_done |-> $past(instr_busy)) else $error("done outside run");
  a_strobe_in_busy: assert property (($fell(alt_function_port[7]) || $fell(alt_function_port[6]))
    |-> (instr_busy || $past(instr_busy))) else $error("strobe outside data cycle");
  a_pull_exclusive: assert property ((alt_port_pull_down & alt_port_strong_up) == 8'h00)
    else $error("pull up and down together");
  a_strong_burst: assert property ($rose(alt_port_strong_up[0]) |-> alt_port_strong_up[0] [*2]
    ##1 !alt_port_strong_up[0]) else $error("strong pull-up burst length wrong");
  a_slow_timer: assert property ((timer_tick[1] && timer_fast_sel[1] == 1'b0) |=> slow_gap)
    else $error("slow timer period wrong");
  a_fetch_follow: assert property ($fell(ext_fetch_select_n) |-> ##[1:4] fetch_external)
    else $error("external fetch not taken");
endmodule // fast_core_checker

// file: test/ext_memory_model.sv
`timescale 1ns/1ns
// external memory and peripherals on port 3; counts strobes, pulls pins low on demand
module ext_memory_model (
  input wire        clk,
  input wire        rst_n,
  input wire [7:0]  alt_function_port,
  input wire [7:0]  upper_addr_port,
  input wire [7:0]  drive_low,
  output wire [7:0] pin_level,
  output integer    rd_count,
  output integer    wr_count,
  output reg [7:0]  last_addr
);
  reg [7:0] prev_reg;
  // weak pull-up keeps an undriven pin high; any driver low wins
  assign pin_level = alt_function_port & ~drive_low;
  // count falling strobes; address sampled while a strobe is low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 8'hFF;
      rd_count <= 0;
      wr_count <= 0;
      last_addr <= 8'h00;
    end else begin
      prev_reg <= alt_function_port;
      if (prev_reg[7] && !alt_function_port[7]) rd_count <= rd_count + 1;
      if (prev_reg[6] && !alt_function_port[6]) wr_count <= wr_count + 1;
      if (!alt_function_port[7] || !alt_function_port[6]) last_addr <= upper_addr_port;
    end
  end
endmodule // ext_memory_model

// file: test/fast_core_cycle_timing_tb.sv
`timescale 1ns/1ns
`include "cycle_timing_defs.vh"
`define CHECK(got, exp) begin comparisons = comparisons + 1; if ((got) !== (exp)) begin bad_count = bad_count + 1; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module fast_core_cycle_timing_tb;
  // start length, bytes 2..5, clamp 7, ext read, ext write, dir-dir, clamp 0
  localparam [79:0] TAB = 80'h2D121B242D3D4A8ACB01;
  reg        clk = 1'b0, rst_n = 1'b0, ext_fetch_select_n = 1'b1, instr_start = 1'b0;
  reg  [1:0] instr_class = 2'h0, timer_fast_sel = 2'h0;
  reg  [2:0] instr_bytes = 3'h1;
  reg        internal_ram_sel = 1'b0, alt_port_write = 1'b0, serial0_tx = 1'b1;
  reg  [7:0] ext_addr_high = 8'hA5, upper_port_latch = 8'hFF, alt_port_latch = 8'hFF, drive_low = 8'h00;
  wire       ale, mcycle_end, instr_busy, instr_done, fetch_external, internal_ram_access;
  wire       serial0_rx, ext_irq_a, ext_irq_b, timer_a_count_in, timer_b_count_in;
  wire [7:0] upper_addr_port, alt_function_port, alt_port_pull_down, alt_port_strong_up, alt_port_weak_up;
  wire [7:0] pin_level, last_addr;
  wire [1:0] timer_tick;
  integer    bad_count = 0, comparisons = 0, n, k, rd_count, wr_count;
  always #25 clk = ~clk;
  fast_core_cycle_timing i_fast_core_cycle_timing (.clk(clk), .rst_n(rst_n),
    .ext_fetch_select_n(ext_fetch_select_n), .instr_start(instr_start), .instr_class(instr_class),
    .instr_bytes(instr_bytes), .internal_ram_sel(internal_ram_sel), .ext_addr_high(ext_addr_high),
    .upper_port_latch(upper_port_latch), .alt_port_latch(alt_port_latch), .alt_port_write(alt_port_write),
    .serial0_tx(serial0_tx), .timer_fast_sel(timer_fast_sel), .alt_function_port_in(pin_level), .ale(ale),
    .mcycle_end(mcycle_end), .instr_busy(instr_busy), .instr_done(instr_done), .fetch_external(fetch_external),
    .internal_ram_access(internal_ram_access), .upper_addr_port(upper_addr_port),
    .alt_function_port(alt_function_port), .alt_port_pull_down(alt_port_pull_down),
    .alt_port_strong_up(alt_port_strong_up), .alt_port_weak_up(alt_port_weak_up), .serial0_rx(serial0_rx),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .timer_a_count_in(timer_a_count_in),
    .timer_b_count_in(timer_b_count_in), .timer_tick(timer_tick));
  ext_memory_model i_ext_memory_model (.clk(clk), .rst_n(rst_n), .alt_function_port(alt_function_port),
    .upper_addr_port(upper_addr_port), .drive_low(drive_low), .pin_level(pin_level), .rd_count(rd_count),
    .wr_count(wr_count), .last_addr(last_addr));
  task print_verdict;
    begin
      $display("counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task do_reset;
    begin
      @(negedge clk) rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
    end
  endtask
  // clocks until the next done (w 0) or timer a tick (w 1); also ends a start pulse
  task gap(input integer w, output integer cnt);
    integer i;
    begin
      cnt = 0;
      for (i = 0; i < 300 && cnt == 0; i = i + 1) begin
        @(negedge clk) if (instr_start) instr_start = 1'b0;
        if (w == 0 ? instr_done === 1'b1 : timer_tick[0] === 1'b1) cnt = i + 1;
      end
    end
  endtask
  task issue(input integer idx);
    begin
      instr_class = TAB[79-8*idx -: 2];
      instr_bytes = TAB[77-8*idx -: 3];
      instr_start = 1'b1;
    end
  endtask
  task t_reset;
    begin
      do_reset;
      `CHECK(alt_function_port, `BYTE_ONES)
      `CHECK(alt_port_weak_up, `BYTE_ONES)
      `CHECK(alt_port_pull_down, `BYTE_ZERO)
      `CHECK(upper_addr_port, `BYTE_ONES)
      `CHECK(instr_busy, 1'b0)
      n = 0;
      repeat (8) @(negedge clk);
      repeat (40) @(negedge clk) if (ale === 1'b1) n = n + 1;
      `CHECK(n, 10)
      $display("test reset_values done");
    end
  endtask
  // back-to-back run: each done-to-done gap is four clocks per machine cycle
  task t_lengths;
    begin
      issue(0);
      repeat (8) @(negedge clk) instr_start = 1'b0;
      for (k = 1; k <= 10; k = k + 1) begin
        if (k < 10) issue(k);
        gap(0, n);
        if (k > 1) `CHECK(n, 4 * TAB[74-8*(k-1) -: 3])
      end
      `CHECK(instr_busy, 1'b0)
      `CHECK(rd_count, 1)
      `CHECK(wr_count, 1)
      `CHECK(last_addr, ext_addr_high)
      $display("test lengths done");
    end
  endtask
  task t_timers;
    begin
      gap(1, n);
      gap(1, n);
      `CHECK(n, `TIMER_SLOW_CLKS)
      timer_fast_sel = 2'h1;
      gap(1, n);
      gap(1, n);
      `CHECK(n, `TIMER_FAST_CLKS)
      timer_fast_sel = 2'h0;
      $display("test timers done");
    end
  endtask
  task t_port_pin;
    begin
      alt_port_latch = 8'hFE;
      alt_port_write = 1'b1;
      @(negedge clk) alt_port_write = 1'b0;
      repeat (10) @(negedge clk);
      `CHECK(alt_port_pull_down[0], 1'b1)
      `CHECK(alt_function_port[0], 1'b0)
      alt_port_latch = 8'hFF;
      alt_port_write = 1'b1;
      @(negedge clk) alt_port_write = 1'b0;
      n = 0;
      repeat (6) @(negedge clk) if (alt_port_strong_up[0] === 1'b1) n = n + 1;
      `CHECK(n, 2)
      `CHECK({alt_port_weak_up[0], alt_port_pull_down[0]}, 2'h2)
      // far side pulls inputs low; transmit data low reaches bit 1
      drive_low = 8'h3D;
      serial0_tx = 1'b0;
      repeat (6) @(negedge clk);
      `CHECK({timer_b_count_in, timer_a_count_in, ext_irq_b, ext_irq_a, serial0_rx}, 5'h00)
      `CHECK(alt_function_port[1], 1'b0)
      drive_low = 8'h00;
      serial0_tx = 1'b1;
      repeat (6) @(negedge clk);
      `CHECK({timer_b_count_in, timer_a_count_in, ext_irq_b, ext_irq_a, serial0_rx}, 5'h1F)
      $display("test port_pin done");
    end
  endtask
  task t_fetch;
    begin
      ext_fetch_select_n = 1'b0;
      internal_ram_sel = 1'b1;
      upper_port_latch = 8'h3C;
      repeat (6) @(negedge clk);
      `CHECK(fetch_external, 1'b1)
      `CHECK(internal_ram_access, 1'b1)
      `CHECK(upper_addr_port, upper_port_latch)
      // a program fetch from outside puts the upper address on the port
      issue(1);
      gap(0, n);
      `CHECK(upper_addr_port, ext_addr_high)
      @(negedge clk);
      `CHECK(upper_addr_port, upper_port_latch)
      ext_fetch_select_n = 1'b1;
      internal_ram_sel = 1'b0;
      upper_port_latch = 8'hFF;
      $display("test fetch done");
    end
  endtask
  // main sequence; the final reset lands in mid-run on purpose
  initial begin
    t_reset;
    t_lengths;
    t_timers;
    t_port_pin;
    t_fetch;
    // an instruction is still running when this reset hits
    issue(0);
    @(negedge clk) instr_start = 1'b0;
    repeat (6) @(negedge clk);
    t_reset;
    print_verdict;
  end
  // whole run is a few hundred clocks; this cuts a hang short
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // fast_core_cycle_timing_tb
bind fast_core_cycle_timing fast_core_checker i_fast_core_checker (.clk(clk), .rst_n(rst_n),
  .ext_fetch_select_n(ext_fetch_select_n), .timer_fast_sel(timer_fast_sel), .ale(ale), .mcycle_end(mcycle_end),
  .instr_busy(instr_busy), .instr_done(instr_done), .fetch_external(fetch_external),
  .alt_function_port(alt_function_port), .alt_port_pull_down(alt_port_pull_down),
  .alt_port_strong_up(alt_port_strong_up), .timer_tick(timer_tick));
